// File: rtl/timer_counter_channels_map.svh
// register offsets, field positions and reset values of the timer block
// assumes a 32-bit apb slave, one aligned word per register
// Overview of operation
// [RL1] writing the reset bit clears counter and prescaler, then counting restarts at zero
// [RL2] reset bit clears itself, always reads zero, cleared by system reset
// [RL3] stop and reset written together leave the counter halted at zero
// [RL4] prescale select: codes 0..6 divide bus clock by 2^code, 7 is external pin
// [RL5] counter bytes read-only; high read latches low byte until low byte read
// [RL6] counter bytes read zero after system reset and after counter reset
// [RL7] low-byte latch holds through a break until the low byte is read
// [RL8] full-duty bit with overflow-toggle set forces pwm output to 100 percent
// [RL9] full-duty change takes effect only from the next pwm period
// [RL10] channel value pair holds capture value or compare value; reset content undefined
// [RL11] in capture mode a high-byte read blocks captures until low byte read
// [RL12] in compare mode a high-byte write blocks compares until low byte written
// [RL13] sixteen-bit up-counter advances on each prescaled tick unless stopped
// [RL14] software reads counter high first and writes channel high byte first
`ifndef TIMER_COUNTER_CHANNELS_MAP_SVH
`define TIMER_COUNTER_CHANNELS_MAP_SVH

`define TC_OFF_CTRL     12'h000
`define TC_OFF_CNT_HI   12'h004
`define TC_OFF_CNT_LO   12'h008
`define TC_OFF_CH0_CTRL 12'h010
`define TC_OFF_CH0_HI   12'h014
`define TC_OFF_CH0_LO   12'h018
`define TC_OFF_CH1_CTRL 12'h020
`define TC_OFF_CH1_HI   12'h024
`define TC_OFF_CH1_LO   12'h028

// control register fields
`define TC_CTRL_PS_LSB  0
`define TC_CTRL_RST_BIT 4
`define TC_CTRL_STP_BIT 5
`define TC_CTRL_RESET   8'h00

// channel control fields
`define TC_CH_MAX_BIT   0
`define TC_CH_TOV_BIT   1
`define TC_CH_MSA_BIT   2
`define TC_CH_MSB_BIT   3
`define TC_CH_EDGE_BIT  4
`define TC_CH_RESET     8'h00

`define TC_PS_EXT       3'h7
`define TC_NUM_CH       2

`endif

// File: rtl/timer_counter_channels_pkg.sv
// types shared by the timer block
// assumes the map header supplies the numbers
package timer_counter_channels_pkg;
  typedef logic [2:0]  prescale_t;
  typedef logic [15:0] count_t;
  typedef logic [7:0]  byte_t;
endpackage : timer_counter_channels_pkg

// File: rtl/timer_channel.sv
// one capture / compare / pwm channel of the timer
// assumes counter and tick come from the same clock domain
`timescale 1ns/1ps
`default_nettype none
`include "timer_counter_channels_map.svh"
module timer_channel
  import timer_counter_channels_pkg::*;
(
  input  wire logic   clk_sys,
  input  wire logic   srst,
  input  wire count_t count,
  input  wire logic   tick,
  input  wire logic   wrap,
  input  wire byte_t  ctrl,
  input  wire logic   wr_hi,
  input  wire logic   wr_lo,
  input  wire logic   rd_hi,
  input  wire logic   rd_lo,
  input  wire byte_t  wdata,
  input  wire logic   cap_in,
  output count_t      value,
  output logic        pwm_out
);
  logic   capture_mode;
  logic   cap_block_r;
  logic   cmp_block_r;
  logic   cap_d_r;
  logic   max_act_r;
  count_t value_r;
  logic   edge_seen;
  logic   match;

  assign capture_mode = ~ctrl[`TC_CH_MSB_BIT] & ~ctrl[`TC_CH_MSA_BIT];
  assign edge_seen    = ctrl[`TC_CH_EDGE_BIT] ? (~cap_in & cap_d_r) : (cap_in & ~cap_d_r);
  assign match        = ~capture_mode & ~cmp_block_r & tick & (count == value_r);
  assign value        = value_r;

  // capture input already synchronised by the top; one delay for edge detect
  always_ff @(posedge clk_sys) begin
    if (srst) cap_d_r <= 1'b0;
    else      cap_d_r <= cap_in;
  end

  // interlocks: read-high blocks capture, write-high blocks compare
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      cap_block_r <= 1'b0;
      cmp_block_r <= 1'b0;
    end else begin
      if (rd_lo)                     cap_block_r <= 1'b0;
      else if (rd_hi && capture_mode) cap_block_r <= 1'b1; // [RL11]
      if (wr_lo)                     cmp_block_r <= 1'b0;
      else if (wr_hi && !capture_mode) cmp_block_r <= 1'b1; // [RL12]
    end
  end

  // value register has no reset: content undefined after reset
  always_ff @(posedge clk_sys) begin
    if (wr_hi) value_r[15:8] <= wdata;
    else if (capture_mode && !cap_block_r && edge_seen) value_r <= count; // [RL10]
    if (wr_lo) value_r[7:0] <= wdata;
  end

  // full-duty sampled only at period wrap so a change waits for the next period
  always_ff @(posedge clk_sys) begin
    if (srst)      max_act_r <= 1'b0;
    else if (wrap) max_act_r <= ctrl[`TC_CH_MAX_BIT] & ctrl[`TC_CH_TOV_BIT]; // [RL9]
  end

  // pwm: set at wrap, clear on match, pinned high while full-duty active
  always_ff @(posedge clk_sys) begin
    if (srst)                      pwm_out <= 1'b0;
    else if (max_act_r)            pwm_out <= 1'b1; // [RL8]
    else if (capture_mode)         pwm_out <= 1'b0;
    else if (wrap)                 pwm_out <= 1'b1;
    else if (match)                pwm_out <= 1'b0;
  end
endmodule : timer_channel
`default_nettype wire

// File: rtl/timer_counter_channels.sv
// timer top: apb registers, prescaler, 16-bit counter, two channels
// assumes apb on clk_sys; external clock and capture pins are asynchronous
//
// The APB slave port and the register offsets were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "timer_counter_channels_map.svh"
module timer_counter_channels
  import timer_counter_channels_pkg::*;
(
  input  wire logic        clk_sys,
  input  wire logic        srst,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        external_timer_clock_pin,
  input  wire logic        break_active,
  input  wire logic [1:0]  capture_pin,
  output logic      [1:0]  pwm_pin
);
  import timer_counter_channels_pkg::*;

  prescale_t   clock_prescale_select_r;
  logic        counter_stop_bit_r;
  logic        counter_reset_req;
  logic [5:0]  presc_r;
  count_t      count_r;
  byte_t       lo_latch_r;
  logic        lo_latched_r;
  logic [2:0]  ext_sync_r;
  logic [1:0]  cap_s1_r;
  logic [1:0]  cap_s2_r;
  byte_t       ch_ctrl_r [`TC_NUM_CH];
  count_t      ch_value  [`TC_NUM_CH];
  logic [1:0]  ch_pwm;
  logic        tick;
  logic        wrap;
  logic        access;
  logic        wr;
  logic        rd;
  logic [31:0] rdata_nxt;
  logic        unmapped;

  // one wait state; writes land only at the edge where pready is seen high,
  // reads sample at the access edge so the low-byte latch matches the high byte
  assign access = psel & penable & ~pready;
  assign wr     = psel & penable & pready & pwrite;
  assign rd     = access & ~pwrite;
  assign counter_reset_req = wr && (paddr == `TC_OFF_CTRL) && pwdata[`TC_CTRL_RST_BIT]; // [RL1]

  // control register; reset bit is never stored, so it reads zero
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      clock_prescale_select_r <= 3'h0; // [RL4]
      counter_stop_bit_r      <= 1'b0;
    end else if (wr && paddr == `TC_OFF_CTRL) begin
      clock_prescale_select_r <= pwdata[`TC_CTRL_PS_LSB +: 3];
      counter_stop_bit_r      <= pwdata[`TC_CTRL_STP_BIT];
    end
  end

  // external clock pin: two flops, third only for edge detection
  always_ff @(posedge clk_sys) begin
    if (srst) ext_sync_r <= 3'h0;
    else      ext_sync_r <= {ext_sync_r[1:0], external_timer_clock_pin};
  end

  // capture pins synchronised before the channels look at them
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      cap_s1_r <= 2'h0;
      cap_s2_r <= 2'h0;
    end else begin
      cap_s1_r <= capture_pin;
      cap_s2_r <= cap_s1_r;
    end
  end

  // free prescaler; cleared by counter reset
  always_ff @(posedge clk_sys) begin
    if (srst || counter_reset_req) presc_r <= 6'h00; // [RL1]
    else                           presc_r <= presc_r + 6'h01;
  end

  // tick selection: divide by 2^code, code 7 takes rising edge of pin
  always_comb begin
    case (clock_prescale_select_r) // [RL4]
      3'h0:    tick = 1'b1;
      3'h1:    tick = (presc_r[0]   == 1'h1);
      3'h2:    tick = (presc_r[1:0] == 2'h3);
      3'h3:    tick = (presc_r[2:0] == 3'h7);
      3'h4:    tick = (presc_r[3:0] == 4'hf);
      3'h5:    tick = (presc_r[4:0] == 5'h1f);
      3'h6:    tick = (presc_r[5:0] == 6'h3f);
      default: tick = ext_sync_r[1] & ~ext_sync_r[2];
    endcase
  end

  assign wrap = tick & ~counter_stop_bit_r & (count_r == 16'hffff);

  // counter: reset wins, stop holds, else advance per tick
  always_ff @(posedge clk_sys) begin
    if (srst || counter_reset_req) count_r <= 16'h0000; // [RL1] [RL3] [RL6]
    else if (!counter_stop_bit_r && tick) count_r <= count_r + 16'h0001; // [RL13]
  end

  // coherent byte read: high read latches low byte, held until low read
  always_ff @(posedge clk_sys) begin
    if (srst || counter_reset_req) begin
      lo_latch_r   <= 8'h00; // [RL6]
      lo_latched_r <= 1'b0;
    end else if (rd && paddr == `TC_OFF_CNT_LO) begin
      lo_latched_r <= 1'b0;
    end else if (rd && paddr == `TC_OFF_CNT_HI && !lo_latched_r) begin
      lo_latch_r   <= count_r[7:0]; // [RL5] [RL7]
      lo_latched_r <= 1'b1;
    end
  end

  // channel control registers
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      ch_ctrl_r[0] <= `TC_CH_RESET;
      ch_ctrl_r[1] <= `TC_CH_RESET;
    end else if (wr) begin
      if (paddr == `TC_OFF_CH0_CTRL) ch_ctrl_r[0] <= pwdata[7:0];
      if (paddr == `TC_OFF_CH1_CTRL) ch_ctrl_r[1] <= pwdata[7:0];
    end
  end

  timer_channel u_ch0 (
    .clk_sys (clk_sys),
    .srst    (srst),
    .count   (count_r),
    .tick    (tick & ~counter_stop_bit_r),
    .wrap    (wrap),
    .ctrl    (ch_ctrl_r[0]),
    .wr_hi   (wr && paddr == `TC_OFF_CH0_HI),
    .wr_lo   (wr && paddr == `TC_OFF_CH0_LO),
    .rd_hi   (rd && paddr == `TC_OFF_CH0_HI),
    .rd_lo   (rd && paddr == `TC_OFF_CH0_LO),
    .wdata   (pwdata[7:0]),
    .cap_in  (cap_s2_r[0]),
    .value   (ch_value[0]),
    .pwm_out (ch_pwm[0])
  );

  timer_channel u_ch1 (
    .clk_sys (clk_sys),
    .srst    (srst),
    .count   (count_r),
    .tick    (tick & ~counter_stop_bit_r),
    .wrap    (wrap),
    .ctrl    (ch_ctrl_r[1]),
    .wr_hi   (wr && paddr == `TC_OFF_CH1_HI),
    .wr_lo   (wr && paddr == `TC_OFF_CH1_LO),
    .rd_hi   (rd && paddr == `TC_OFF_CH1_HI),
    .rd_lo   (rd && paddr == `TC_OFF_CH1_LO),
    .wdata   (pwdata[7:0]),
    .cap_in  (cap_s2_r[1]),
    .value   (ch_value[1]),
    .pwm_out (ch_pwm[1])
  );

  // read mux; reset bit always reads zero
  always_comb begin
    rdata_nxt = 32'h0000_0000;
    unmapped  = 1'b0;
    case (paddr)
      `TC_OFF_CTRL:     rdata_nxt[7:0] = {2'h0, counter_stop_bit_r, 2'h0,
                                          clock_prescale_select_r}; // [RL2]
      `TC_OFF_CNT_HI:   rdata_nxt[7:0] = count_r[15:8];
      `TC_OFF_CNT_LO:   rdata_nxt[7:0] = lo_latched_r ? lo_latch_r : count_r[7:0]; // [RL5]
      `TC_OFF_CH0_CTRL: rdata_nxt[7:0] = ch_ctrl_r[0];
      `TC_OFF_CH0_HI:   rdata_nxt[7:0] = ch_value[0][15:8];
      `TC_OFF_CH0_LO:   rdata_nxt[7:0] = ch_value[0][7:0];
      `TC_OFF_CH1_CTRL: rdata_nxt[7:0] = ch_ctrl_r[1];
      `TC_OFF_CH1_HI:   rdata_nxt[7:0] = ch_value[1][15:8];
      `TC_OFF_CH1_LO:   rdata_nxt[7:0] = ch_value[1][7:0];
      default:          unmapped = 1'b1;
    endcase
  end

  // apb answer registered; one wait state, pready pulses one cycle
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      pready  <= 1'b0;
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      pready  <= access;
      pslverr <= access & unmapped;
      if (rd) prdata <= rdata_nxt;
    end
  end

  // pwm pins registered
  always_ff @(posedge clk_sys) begin
    if (srst) pwm_pin <= 2'h0;
    else      pwm_pin <= ch_pwm;
  end

  // break_active only documents intent: latch already persists through breaks
  logic unused_break;
  assign unused_break = break_active;
endmodule : timer_counter_channels
`default_nettype wire

// File: bench/timer_counter_channels_chk.sv
// bus and pin checks on the timer top
// assumes the map header offsets and one wait state per transfer
`timescale 1ns/1ps
`default_nettype none
`include "timer_counter_channels_map.svh"
module timer_counter_channels_chk (
  input wire logic        clk_sys,
  input wire logic        srst,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic [1:0]  pwm_pin
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (srst);
  logic       halt_r;
  logic [1:0] mode0_r;
  wire done = pready && psel && penable;
  wire rdc  = done && !pwrite && (paddr == `TC_OFF_CNT_HI || paddr == `TC_OFF_CNT_LO);
  wire mapped = paddr inside {`TC_OFF_CTRL, `TC_OFF_CNT_HI, `TC_OFF_CNT_LO,
    `TC_OFF_CH0_CTRL, `TC_OFF_CH0_HI, `TC_OFF_CH0_LO,
    `TC_OFF_CH1_CTRL, `TC_OFF_CH1_HI, `TC_OFF_CH1_LO};
  // shadows of what software last wrote, taken when the answer lands
  always_ff @(posedge clk_sys) begin
    if (srst) halt_r <= 1'b0;
    else if (done && pwrite && paddr == `TC_OFF_CTRL) halt_r <= pwdata[4] && pwdata[5];
  end
  always_ff @(posedge clk_sys) begin
    if (srst) mode0_r <= 2'b00;
    else if (done && pwrite && paddr == `TC_OFF_CH0_CTRL) mode0_r <= pwdata[3:2];
  end
  sequence s_access; psel && penable && !pready; endsequence
  property p_answer; s_access |=> pready; endproperty
  a_answer: assert property (p_answer) else $error("access not answered");
  property p_pulse; pready |=> !pready; endproperty
  a_pulse: assert property (p_pulse) else $error("ready longer than one cycle");
  property p_only; pready |-> psel && penable; endproperty
  a_only: assert property (p_only) else $error("ready outside access");
  property p_ctlrd; done && !pwrite && paddr == `TC_OFF_CTRL |-> !prdata[4]; endproperty
  a_ctlrd: assert property (p_ctlrd) else $error("reset bit read as one");
  property p_upper; done && !pwrite |-> prdata[31:8] == 24'h0; endproperty
  a_upper: assert property (p_upper) else $error("upper read bits set");
  property p_unmap; done && !mapped |-> pslverr && (pwrite || prdata == 32'h0); endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped access accepted");
  property p_map; done && mapped |-> !pslverr; endproperty
  a_map: assert property (p_map) else $error("mapped access refused");
  property p_halt; halt_r && rdc |-> prdata == 32'h0; endproperty
  a_halt: assert property (p_halt) else $error("halted counter not zero");
  property p_cap; (mode0_r == 2'b00) [*3] |-> !pwm_pin[0]; endproperty
  a_cap: assert property (p_cap) else $error("pwm active in capture mode");
endmodule : timer_counter_channels_chk
bind timer_counter_channels timer_counter_channels_chk chk (.clk_sys(clk_sys), .srst(srst),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .pwm_pin(pwm_pin));
`default_nettype wire

// File: bench/test_timer_counter_channels.sv
// self-checking bench for the timer top over apb
// assumes one wait state answers and the map header offsets
`timescale 1ns/1ps
`default_nettype none
`include "timer_counter_channels_map.svh"
module test_timer_counter_channels;
  import timer_counter_channels_pkg::*;
  logic clk_sys, srst, psel, penable, pwrite, ext, brk, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic        pready, pslverr;
  logic [1:0]  cap, pwm;
  logic [7:0]  h, l, a;
  logic [15:0] v0, v1;
  int          bad_count, tests_run;
  timer_counter_channels uut (.clk_sys(clk_sys), .srst(srst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .external_timer_clock_pin(ext), .break_active(brk),
    .capture_pin(cap), .pwm_pin(pwm));
  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end
  task automatic final_report();
    if (bad_count == 0 && tests_run > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : final_report
  task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      bad_count++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check
  // one apb transfer; bounded wait, released only at the ready edge
  task automatic apb(input logic w, input logic [11:0] ad, input logic [31:0] d);
    int n;
    psel <= 1'b1; pwrite <= w; paddr <= ad; pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      bad_count++;
      final_report();
    end
    q = prdata; err = pslverr;
    psel <= 1'b0; penable <= 1'b0;
    @(posedge clk_sys);
  endtask : apb
  task automatic wr(input logic [11:0] ad, input logic [7:0] d);
    apb(1'b1, ad, {24'h0, d});
  endtask : wr
  task automatic rd(input logic [11:0] ad, output logic [7:0] d);
    apb(1'b0, ad, 32'h0);
    d = q[7:0];
  endtask : rd
  // clear, run k bus clocks, or k pulses on the pin for code 7, then 8 more bus clocks, stop, read high then low
  task automatic meas(input logic [2:0] ps, input int k, output logic [15:0] v);
    wr(`TC_OFF_CTRL, 8'h30 | ps);
    wr(`TC_OFF_CTRL, {5'h0, ps});
    if (ps == `TC_PS_EXT) repeat (k) begin
      ext <= 1'b1; repeat (4) @(posedge clk_sys);
      ext <= 1'b0; repeat (4) @(posedge clk_sys);
    end else repeat (k) @(posedge clk_sys);
    repeat (8) @(posedge clk_sys);
    wr(`TC_OFF_CTRL, 8'h20 | ps);
    rd(`TC_OFF_CNT_HI, h); rd(`TC_OFF_CNT_LO, l); v = {h, l};
  endtask : meas
  task automatic pulse();
    cap <= 2'b11; repeat (4) @(posedge clk_sys);
    cap <= 2'b00; repeat (6) @(posedge clk_sys);
  endtask : pulse
  initial begin
    srst = 1'b1; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 12'h0;
    pwdata = 32'h0; ext = 1'b0; brk = 1'b0; cap = 2'b00; bad_count = 0; tests_run = 0;
    repeat (3) @(posedge clk_sys);
    srst <= 1'b0;
    @(posedge clk_sys);
    rd(`TC_OFF_CTRL, h); check("ctrl reset", h, 16'h0);
    // halt at zero, read-only counter bytes, self-clearing reset bit
    wr(`TC_OFF_CTRL, 8'h30);
    rd(`TC_OFF_CNT_HI, h); rd(`TC_OFF_CNT_LO, l); check("halted count", {h, l}, 16'h0);
    wr(`TC_OFF_CNT_HI, 8'hff); rd(`TC_OFF_CNT_HI, h); check("count ro", h, 16'h0);
    rd(`TC_OFF_CTRL, h); check("ctrl readback", h, 16'h20);
    // every clock source: step between runs of 0 and 64 bus clocks, or 0 and 5 pin pulses
    for (int p = 0; p < 8; p++) begin
      meas(p[2:0], 0, v0);
      meas(p[2:0], (p == 7) ? 5 : 64, v1);
      check("count step", v1 - v0, (p == 7) ? 16'd5 : (16'd64 >> p));
    end
    // low byte latched by the first high read, held through a break
    wr(`TC_OFF_CTRL, 8'h30); wr(`TC_OFF_CTRL, 8'h00);
    rd(`TC_OFF_CNT_HI, h); rd(`TC_OFF_CNT_LO, a);
    wr(`TC_OFF_CTRL, 8'h30); wr(`TC_OFF_CTRL, 8'h00);
    brk <= 1'b1;
    rd(`TC_OFF_CNT_HI, h); repeat (100) @(posedge clk_sys); rd(`TC_OFF_CNT_HI, h);
    rd(`TC_OFF_CNT_LO, l); brk <= 1'b0;
    check("latched low", l, a);
    // unmapped address refused both ways
    apb(1'b1, 12'h0fc, 32'hff); check("unmapped wr err", err, 1'b1);
    apb(1'b0, 12'h0fc, 32'h0); check("unmapped rd", {err, q[14:0]}, 16'h8000);
    // compare value readback
    wr(`TC_OFF_CH0_CTRL, 8'h04);
    wr(`TC_OFF_CH0_HI, 8'h12); wr(`TC_OFF_CH0_LO, 8'h34);
    rd(`TC_OFF_CH0_HI, h); rd(`TC_OFF_CH0_LO, l); check("compare value", {h, l}, 16'h1234);
    // capture blocked between high and low reads
    wr(`TC_OFF_CTRL, 8'h30); wr(`TC_OFF_CH0_CTRL, 8'h00); pulse();
    rd(`TC_OFF_CH0_HI, h); check("capture hi", h, 16'h0);
    wr(`TC_OFF_CTRL, 8'h00); repeat (20) @(posedge clk_sys); pulse();
    wr(`TC_OFF_CTRL, 8'h20);
    rd(`TC_OFF_CH0_LO, l); check("capture blocked", l, 16'h0);
    pulse();
    rd(`TC_OFF_CH0_HI, h); rd(`TC_OFF_CH0_LO, l); v0 = {h, l};
    rd(`TC_OFF_CNT_HI, h); rd(`TC_OFF_CNT_LO, l); check("capture value", v0, {h, l});
    // one full period: both pwm set at wrap, match clears only the plain one
    wr(`TC_OFF_CH0_CTRL, 8'h04); wr(`TC_OFF_CH1_CTRL, 8'h07);
    wr(`TC_OFF_CH0_HI, 8'h00); wr(`TC_OFF_CH0_LO, 8'h10);
    wr(`TC_OFF_CH1_HI, 8'h00); wr(`TC_OFF_CH1_LO, 8'h10);
    wr(`TC_OFF_CTRL, 8'h30); wr(`TC_OFF_CTRL, 8'h00);
    repeat (4) @(posedge clk_sys);
    check("full duty waits", pwm, 16'h0);
    repeat (65536) @(posedge clk_sys);
    check("pwm at wrap", pwm, 16'h3);
    repeat (40) @(posedge clk_sys);
    check("full duty", pwm, 16'h2);
    final_report();
  end
endmodule : test_timer_counter_channels
`default_nettype wire
